/* verilog/rpsc_params.svh */
/*
 * Offsets, bit positions, reset values and response codes of the
 * reset pin strap capture block.
 * Assumes it is included by its bare name wherever these are needed.
 */
`ifndef RPSC_PARAMS_SVH
`define RPSC_PARAMS_SVH

// Byte addresses of the two capture registers
`define RPSC_ADDR_LOW 32'h40000000
`define RPSC_ADDR_HIGH 32'h40000004

// Width of the captured field in each register
`define RPSC_CAP_WIDTH 8

// Bit positions in the low capture register
`define RPSC_LOW_SER0_OUT 7
`define RPSC_LOW_SER0_IN 6
`define RPSC_LOW_SER0_CLK 5
`define RPSC_LOW_SER0_SEL 4
`define RPSC_LOW_SER0_ENA 3
`define RPSC_LOW_SER1_OUT 2
`define RPSC_LOW_SER1_IN 1
`define RPSC_LOW_SER1_CLK 0

// Bit positions in the high capture register
`define RPSC_HIGH_SER1_SEL 7
`define RPSC_HIGH_SER1_ENA 6
`define RPSC_HIGH_HOST_CS 5
`define RPSC_HIGH_HOST_D0 4
`define RPSC_HIGH_MEM_D16 3
`define RPSC_HIGH_TX_FS 2
`define RPSC_HIGH_RX_FS 1
`define RPSC_HIGH_AUD_D0 0

// AXI response codes
`define RPSC_RESP_OKAY 2'h0
`define RPSC_RESP_DECERR 2'h3

// Reset values
`define RPSC_EXT_RST_IDLE 1'h1
`define RPSC_RST_ZERO_32 32'h00000000
`define RPSC_RST_ZERO_2 2'h0
`define RPSC_RST_ZERO_1 1'h0

`endif

/* verilog/rpsc_pkg.sv */
/*
 * Types of the reset pin strap capture block: the strap pin bundle and
 * the packed state of the top module.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package rpsc_pkg;

    // Sixteen strap pins, packed so that bits 15:8 feed the high register
    typedef struct packed {
        logic audio_or_serial1_select_pin;
        logic audio_or_serial1_enable_pin;
        logic host_port_chip_select_pin;
        logic host_port_data_bit0_pin;
        logic memory_data16_or_host_addr0_pin;
        logic audio0_tx_frame_sync_pin;
        logic audio0_rx_frame_sync_pin;
        logic audio0_data_line0_pin;
        logic serial0_out_or_i2c0_data_pin;
        logic serial0_in_pin;
        logic serial0_clock_or_i2c0_clock_pin;
        logic serial0_select_or_i2c1_clock_pin;
        logic serial0_enable_or_i2c1_data_pin;
        logic audio_or_serial1_out_pin;
        logic audio_or_serial1_in_pin;
        logic audio_or_serial1_clock_pin;
    } rpsc_straps_t;

    // Whole state of the top module
    typedef struct packed {
        logic ext_meta;
        logic ext_sync;
        rpsc_straps_t pins_meta;
        rpsc_straps_t pins_sync;
        logic [7:0] cap_low;
        logic [7:0] cap_high;
        logic aw_have;
        logic w_have;
        logic [31:0] aw_addr;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rpsc_state_t;

endpackage : rpsc_pkg

`default_nettype wire

/* verilog/rpsc_top.sv */
/*
 * Reset pin strap capture: two read-only registers that hold the levels
 * of sixteen strap pins as they stood when the external reset pin rose,
 * reached over an AXI4-Lite slave port.
 * Assumes the strap pins and the external reset pin are asynchronous to
 * aclk, that aresetn is the system reset (which may come from watchdog
 * or debug sources, or overlap the external reset), and that the board
 * holds the external reset pin low for at least three aclk cycles.
 */
`timescale 1ns/1ps
`include "rpsc_params.svh"
`default_nettype none

module rpsc_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n_pin,
    input wire rpsc_pkg::rpsc_straps_t strap_pins,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import rpsc_pkg::*;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Word match on one register; byte offset bits are not looked at
    function automatic logic rpsc_hit(input logic [31:0] addr, input logic [31:0] base);
        rpsc_hit = (addr[31:2] == base[31:2]);
    endfunction : rpsc_hit

    // Response code for an access to the given address
    function automatic logic [1:0] rpsc_resp(input logic [31:0] addr);
        if (rpsc_hit(addr, `RPSC_ADDR_LOW) || rpsc_hit(addr, `RPSC_ADDR_HIGH))
        begin
            rpsc_resp = `RPSC_RESP_OKAY;
        end
        else
        begin
            rpsc_resp = `RPSC_RESP_DECERR;
        end
    endfunction : rpsc_resp

    // Read data for the given address; reserved bits read as zero
    function automatic logic [31:0] rpsc_rdata(
        input logic [31:0] addr,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        rpsc_rdata = `RPSC_RST_ZERO_32;
        if (rpsc_hit(addr, `RPSC_ADDR_LOW))
        begin
            rpsc_rdata[`RPSC_CAP_WIDTH-1:0] = lo;
        end
        else if (rpsc_hit(addr, `RPSC_ADDR_HIGH))
        begin
            rpsc_rdata[`RPSC_CAP_WIDTH-1:0] = hi;
        end
    endfunction : rpsc_rdata

    // ****************************************************************
    // State
    // ****************************************************************

    rpsc_state_t s_reg;
    rpsc_state_t s_next;
    logic aw_take;
    logic w_take;
    logic ar_take;

    // Handshakes of this cycle
    assign aw_take = awvalid && s_reg.awready;
    assign w_take = wvalid && s_reg.wready;
    assign ar_take = arvalid && s_reg.arready;

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Synchronisers, capture tracking and the bus slave
    always_comb
    begin
        s_next = s_reg;

        // Two stages for every asynchronous pin; stage one feeds stage two only
        s_next.ext_meta = ext_reset_n_pin;
        s_next.ext_sync = s_reg.ext_meta;
        s_next.pins_meta = strap_pins;
        s_next.pins_sync = s_reg.pins_meta;

        // Follow the pins while the external reset is held low. Both the
        // reset level and the pins pass the same two stages, so the value
        // frozen at the rise is the one that stood at the reset release.
        if (!s_reg.ext_sync)
        begin
            s_next.cap_low[`RPSC_LOW_SER0_OUT] =
                s_reg.pins_sync.serial0_out_or_i2c0_data_pin;
            s_next.cap_low[`RPSC_LOW_SER0_IN] =
                s_reg.pins_sync.serial0_in_pin;
            s_next.cap_low[`RPSC_LOW_SER0_CLK] =
                s_reg.pins_sync.serial0_clock_or_i2c0_clock_pin;
            s_next.cap_low[`RPSC_LOW_SER0_SEL] =
                s_reg.pins_sync.serial0_select_or_i2c1_clock_pin;
            s_next.cap_low[`RPSC_LOW_SER0_ENA] =
                s_reg.pins_sync.serial0_enable_or_i2c1_data_pin;
            s_next.cap_low[`RPSC_LOW_SER1_OUT] =
                s_reg.pins_sync.audio_or_serial1_out_pin;
            s_next.cap_low[`RPSC_LOW_SER1_IN] =
                s_reg.pins_sync.audio_or_serial1_in_pin;
            s_next.cap_low[`RPSC_LOW_SER1_CLK] =
                s_reg.pins_sync.audio_or_serial1_clock_pin;
            s_next.cap_high[`RPSC_HIGH_SER1_SEL] =
                s_reg.pins_sync.audio_or_serial1_select_pin;
            s_next.cap_high[`RPSC_HIGH_SER1_ENA] =
                s_reg.pins_sync.audio_or_serial1_enable_pin;
            s_next.cap_high[`RPSC_HIGH_HOST_CS] =
                s_reg.pins_sync.host_port_chip_select_pin;
            s_next.cap_high[`RPSC_HIGH_HOST_D0] =
                s_reg.pins_sync.host_port_data_bit0_pin;
            s_next.cap_high[`RPSC_HIGH_MEM_D16] =
                s_reg.pins_sync.memory_data16_or_host_addr0_pin;
            s_next.cap_high[`RPSC_HIGH_TX_FS] =
                s_reg.pins_sync.audio0_tx_frame_sync_pin;
            s_next.cap_high[`RPSC_HIGH_RX_FS] =
                s_reg.pins_sync.audio0_rx_frame_sync_pin;
            s_next.cap_high[`RPSC_HIGH_AUD_D0] =
                s_reg.pins_sync.audio0_data_line0_pin;
        end
        // Otherwise both registers simply hold: nothing else writes them

        // Write address and data are taken in either order
        if (aw_take)
        begin
            s_next.aw_have = 1'h1;
            s_next.aw_addr = awaddr;
        end
        if (w_take)
        begin
            s_next.w_have = 1'h1;
        end

        // Response retires the write; a taken response frees the channels
        if (s_reg.bvalid && bready)
        begin
            s_next.bvalid = 1'h0;
        end
        if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid)
        begin
            // Registers are read only: write data never reaches them
            s_next.bvalid = 1'h1;
            s_next.bresp = rpsc_resp(s_reg.aw_addr);
            s_next.aw_have = 1'h0;
            s_next.w_have = 1'h0;
        end

        // Readies stay low while a beat is held or a response is pending
        s_next.awready = !s_next.aw_have && !s_next.bvalid;
        s_next.wready = !s_next.w_have && !s_next.bvalid;

        // Read answers one edge after the address is taken
        if (s_reg.rvalid && rready)
        begin
            s_next.rvalid = 1'h0;
        end
        if (ar_take)
        begin
            s_next.rvalid = 1'h1;
            s_next.rresp = rpsc_resp(araddr);
            s_next.rdata = rpsc_rdata(araddr, s_reg.cap_low, s_reg.cap_high);
        end
        s_next.arready = !s_next.rvalid;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Capture bytes and pin synchronisers ignore aresetn on purpose: a
    // watchdog or debug reset must not disturb the bytes, and an external
    // reset that rises while aresetn is still low must still be captured.
    // The synchronisers keep following the pins, so leaving aresetn can
    // never look like a rise of the external reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_reg.ext_meta <= s_next.ext_meta;
            s_reg.ext_sync <= s_next.ext_sync;
            s_reg.pins_meta <= s_next.pins_meta;
            s_reg.pins_sync <= s_next.pins_sync;
            s_reg.aw_have <= `RPSC_RST_ZERO_1;
            s_reg.w_have <= `RPSC_RST_ZERO_1;
            s_reg.aw_addr <= `RPSC_RST_ZERO_32;
            s_reg.awready <= `RPSC_RST_ZERO_1;
            s_reg.wready <= `RPSC_RST_ZERO_1;
            s_reg.bvalid <= `RPSC_RST_ZERO_1;
            s_reg.bresp <= `RPSC_RST_ZERO_2;
            s_reg.arready <= `RPSC_RST_ZERO_1;
            s_reg.rvalid <= `RPSC_RST_ZERO_1;
            s_reg.rdata <= `RPSC_RST_ZERO_32;
            s_reg.rresp <= `RPSC_RST_ZERO_2;
            s_reg.cap_low <= s_next.cap_low;
            s_reg.cap_high <= s_next.cap_high;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Every output is a bit of the registered state
    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;

endmodule : rpsc_top

`default_nettype wire

/* verification/rpsc_checker.sv */
/* Checker for the strap capture block: bus answers and captured bytes.
   Assumes it is bound to rpsc_top and sees only that module's ports. */
`timescale 1ns/1ps
`include "rpsc_params.svh"
`default_nettype none
module rpsc_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n_pin,
    input wire rpsc_pkg::rpsc_straps_t strap_pins,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    import rpsc_pkg::*;
    // ****************************************
    // Reference capture and read address
    // ****************************************
    logic ext_q = 1'b1;
    logic seen_rise = 1'b0;
    logic [3:0] quiet = 4'h0;
    rpsc_straps_t ref_pins;
    logic [31:0] rd_addr;
    logic rd_low;
    logic rd_high;
    assign rd_low = {rd_addr[31:2], 2'h0} == `RPSC_ADDR_LOW;
    assign rd_high = {rd_addr[31:2], 2'h0} == `RPSC_ADDR_HIGH;
    // Not tied to aresetn: the capture survives system resets
    always_ff @(posedge aclk)
    begin
        ext_q <= ext_reset_n_pin;
        if (ext_reset_n_pin && !ext_q)
        begin
            ref_pins <= strap_pins;
            seen_rise <= 1'b1;
        end
        quiet <= !ext_reset_n_pin ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
        if (arvalid && arready)
            rd_addr <= araddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Quiet count keeps the synchroniser delay out of the comparison
    property p_rsv; rvalid |-> rdata[31:8] == 24'h000000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_low;
        rvalid && rd_low && seen_rise && quiet == 4'hF |-> rdata[7:0] == ref_pins[7:0] && rresp == 2'h0;
    endproperty
    a_low: assert property (p_low) else $error("low byte wrong");
    property p_high;
        rvalid && rd_high && seen_rise && quiet == 4'hF |-> rdata[7:0] == ref_pins[15:8] && rresp == 2'h0;
    endproperty
    a_high: assert property (p_high) else $error("high byte wrong");
    property p_dec; rvalid && !rd_low && !rd_high |-> rresp == 2'h3 && rdata == 32'h00000000; endproperty
    a_dec: assert property (p_dec) else $error("unmapped read not refused");
    property p_ar_ans; arvalid && arready |=> rvalid && !arready; endproperty
    a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
    property p_r_once; rvalid && rready |=> !rvalid; endproperty
    a_r_once: assert property (p_r_once) else $error("read answer repeated");
    property p_b_once; bvalid && bready |=> !bvalid; endproperty
    a_b_once: assert property (p_b_once) else $error("write answer repeated");
    // Both write channels stay shut while a response is pending
    property p_b_block; bvalid |-> !awready && !wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write channel open during response");
    property p_wr_ok;
        awvalid && awready && {awaddr[31:3], 3'h0} == `RPSC_ADDR_LOW |-> ##[1:4] bvalid && bresp == 2'h0;
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("register write not accepted");
    c_low: cover property (rvalid && rd_low && quiet == 4'hF);
    c_dec: cover property (rvalid && rresp == 2'h3);
    c_wr: cover property (bvalid && bresp == 2'h0);
endmodule : rpsc_checker
`default_nettype wire

/* verification/rpsc_board_model.sv */
/* Board side: strap pin levels and the external reset pin.
   Assumes the bench calls strap_boot after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module rpsc_board_model
(
    input wire logic aclk,
    output var logic ext_reset_n_pin,
    output var rpsc_pkg::rpsc_straps_t strap_pins
);
    import rpsc_pkg::*;
    // Power up with the reset pin held low
    initial
    begin
        ext_reset_n_pin = 1'b0;
        strap_pins = rpsc_straps_t'(16'h0000);
    end
    // Straps settle before the rise; afterwards they flip, so a late capture shows
    task automatic strap_boot(input rpsc_straps_t p);
        begin
            strap_pins <= p;
            ext_reset_n_pin <= 1'b0;
            repeat (6) @(posedge aclk);
            ext_reset_n_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            strap_pins <= rpsc_straps_t'(~p);
        end
    endtask : strap_boot
endmodule : rpsc_board_model
`default_nettype wire

/* verification/rpsc_tb_top.sv */
/* Bench for the strap capture block: AXI4-Lite master tasks and scenarios.
   Assumes the board model drives the straps and the external reset pin. */
`timescale 1ns/1ps
`include "rpsc_params.svh"
`default_nettype none
module rpsc_tb_top;
    import rpsc_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr;
    wire logic ext_reset_n_pin, awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire rpsc_straps_t strap_pins;
    int fail_count = 0;
    int cmp_count = 0;
    logic [31:0] d;
    logic [1:0] rs;
    rpsc_straps_t pats [3] = '{16'hA5C3, 16'h5A3C, 16'hFF00};
    rpsc_board_model board_u (.aclk(aclk), .ext_reset_n_pin(ext_reset_n_pin),
        .strap_pins(strap_pins));
    rpsc_top dut_u (.aclk(aclk), .aresetn(aresetn), .ext_reset_n_pin(ext_reset_n_pin),
        .strap_pins(strap_pins), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    // ****************************************
    // Clock, compare and closing
    // ****************************************
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // ****************************************
    // Bus master: hold each channel until its own handshake
    // ****************************************
    task automatic axi_write(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read
    // Both registers: captured byte low, reserved bits zero
    task automatic check_regs(input rpsc_straps_t p);
        axi_read(`RPSC_ADDR_LOW, d, rs);
        check(d, {24'h000000, p[7:0]});
        check({30'h0, rs}, {30'h0, `RPSC_RESP_OKAY});
        axi_read(`RPSC_ADDR_HIGH, d, rs);
        check(d, {24'h000000, p[15:8]});
        check({30'h0, rs}, {30'h0, `RPSC_RESP_OKAY});
    endtask : check_regs
    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, wdata, araddr} = 96'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            board_u.strap_boot(pats[i]);
            repeat (8) @(posedge aclk);
            check_regs(pats[i]);
        end
        // System reset alone must not recapture the flipped straps
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        check_regs(pats[2]);
        // Write with reserved bits zero: accepted but without effect
        axi_write(`RPSC_ADDR_LOW, 32'h000000FF, rs);
        check({30'h0, rs}, {30'h0, `RPSC_RESP_OKAY});
        check_regs(pats[2]);
        axi_write(32'h40000010, 32'h00000000, rs);
        check({30'h0, rs}, {30'h0, `RPSC_RESP_DECERR});
        axi_read(32'h40000008, d, rs);
        check(d, 32'h00000000);
        check({30'h0, rs}, {30'h0, `RPSC_RESP_DECERR});
        // External reset released while the system reset is still held
        aresetn <= 1'b0;
        board_u.strap_boot(pats[0]);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        check_regs(pats[0]);
        finish_test();
    end
    // Watchdog well beyond the roughly 130 cycles the scenarios need
    initial
    begin
        repeat (3000) @(posedge aclk);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : rpsc_tb_top
bind rpsc_top rpsc_checker chk_u (.aclk(aclk), .aresetn(aresetn),
    .ext_reset_n_pin(ext_reset_n_pin), .strap_pins(strap_pins), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
`default_nettype wire
